// ### udb_data_in.sv
// Device end of an Ultra DMA data-in burst: start, sustain and host pause
//
// Contract
// - Device asserts DMARQ to start; holds it past first strobe negation.
// - Device drives strobe only after drive delay; keeps driving until DMACK drops.
// - Device drives first word only after drive delay from last host change.
// - First strobe negation within first-strobe time, after data setup.
// - Strobe, ready and stop meanings hold only while DMARQ and DMACK asserted.
// - Each new word goes out first; strobe toggles after setup; both edges count.
// - Edges at least one cycle time apart; same-direction edges two apart.
// - Data bus held unchanged at least hold time after each edge.
// - Drive, strobe, hold repeats until data runs out or the burst pauses.
// - Device stops strobe edges within ready-to-final-strobe time of pause.
// - Device pauses only after first word, by withholding edges; resumes by edge.
`timescale 1ns/100ps
`include "udb_params.svh"

module udb_data_in
  import udb_pkg::*;
(
  input  logic      clk_in,           // Core clock, 100 MHz
  input  logic      nrst_in,          // Async reset, active low
  input  logic      link_clk_in,      // Link side clock
  input  udb_mode_t mode_in,          // Ultra DMA mode 0..4
  input  logic      word_valid_in,    // Word offered by core
  input  udb_word_t word_data_in,     // Word to send
  output logic      word_ready_out,   // Word slot free
  output logic      burst_active_out, // Burst request raised
  output logic      dmarq_out,        // DMA request pin
  input  logic      dmack_n_in,       // DMA acknowledge pin, low active
  input  logic      stop_in,          // Stop pin (write strobe line)
  input  logic      hdmardy_n_in,     // Host ready pin (read strobe line), low active
  input  logic      dstrobe_in,       // Strobe pin level, unused
  output logic      dstrobe_out,      // Strobe pin drive value
  output logic      dstrobe_oe_out,   // Strobe pin drive enable
  input  udb_word_t dd_in,            // Data bus level, unused
  output udb_word_t dd_out,           // Data bus drive value
  output logic      dd_oe_out         // Data bus drive enable
);

  // Saturating increment of a timer
  function automatic udb_cnt_t inc(input udb_cnt_t x);
    if (x == `UDB_CNT_MAX) begin
      return x;
    end
    return x + udb_cnt_t'(1);
  endfunction : inc

  // Least time in tenths of ns to link cycles, rounded up, at least one
  // round-up cycle counts
  function automatic udb_cnt_t cyc_up(input logic [15:0] t_x10);
    logic [15:0] s;
    s = t_x10 + (`UDB_LINK_PER_X10 - 16'h0001);
    s = s / `UDB_LINK_PER_X10;
    if (s == 16'h0000) begin
      s = 16'h0001;
    end
    return udb_cnt_t'(s);
  endfunction : cyc_up

  // True once a timer shows n cycles elapsed
  function automatic logic elapsed(input udb_cnt_t tm, input udb_cnt_t n);
    return ({1'b0, tm} + 9'h001) >= {1'b0, n};
  endfunction : elapsed

  // Data setup time per mode
  function automatic logic [15:0] t_dvs(input udb_mode_t m);
    case (m)
      3'h0:    return `UDB_T_DVS_M0;
      3'h1:    return `UDB_T_DVS_M1;
      3'h2:    return `UDB_T_DVS_M2;
      3'h3:    return `UDB_T_DVS_M3;
      default: return `UDB_T_DVS_M4;
    endcase
  endfunction : t_dvs

  // Edge spacing per mode
  function automatic logic [15:0] t_cyc(input udb_mode_t m);
    case (m)
      3'h0:    return `UDB_T_CYC_M0;
      3'h1:    return `UDB_T_CYC_M1;
      3'h2:    return `UDB_T_CYC_M2;
      3'h3:    return `UDB_T_CYC_M3;
      default: return `UDB_T_CYC_M4;
    endcase
  endfunction : t_cyc

  udb_link_s l_q;
  udb_link_s l_d;
  udb_core_s c_q;
  udb_core_s c_d;
  logic [1:0] lrst_q;
  logic       link_rst_n;
  logic       ack;
  logic       rdy;
  logic       stop;
  logic       in_burst;
  logic       edge_ok;
  udb_cnt_t   n_cyc;

  // Reset release synchronised to the link clock
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign link_rst_n = lrst_q[1];

  // Qualified host signals, read only from second sync stage
  always_comb begin
    ack      = !l_q.ack_n_m2;
    in_burst = l_q.dmarq && ack;
    rdy      = in_burst && !l_q.rdy_n_m2;
    stop     = in_burst && l_q.stop_m2;
    n_cyc    = cyc_up(t_cyc(l_q.mode));
    edge_ok  = elapsed(l_q.t_last, n_cyc) &&
               elapsed(l_q.t_prev, n_cyc + n_cyc);
  end

  // Link side sequencer
  always_comb begin
    l_d          = l_q;
    l_d.mode_m1  = mode_in;
    l_d.mode_m2  = l_q.mode_m1;
    l_d.ack_n_m1 = dmack_n_in;
    l_d.ack_n_m2 = l_q.ack_n_m1;
    l_d.stop_m1  = stop_in;
    l_d.stop_m2  = l_q.stop_m1;
    l_d.rdy_n_m1 = hdmardy_n_in;
    l_d.rdy_n_m2 = l_q.rdy_n_m1;
    l_d.req_m1   = c_q.req_t;
    l_d.req_m2   = l_q.req_m1;
    l_d.tmr      = inc(l_q.tmr);
    l_d.t_last   = inc(l_q.t_last);
    l_d.t_prev   = inc(l_q.t_prev);

    // Take a word from the core once the holding slot is empty
    if ((l_q.req_m2 != l_q.ack_t) && !l_q.next_v) begin
      l_d.next_q = c_q.word;
      l_d.next_v = 1'b1;
      l_d.ack_t  = l_q.req_m2;
    end

    case (l_q.st)
      S_IDLE: begin
        l_d.dmarq   = 1'b0;
        l_d.strb_oe = 1'b0;
        l_d.dd_oe   = 1'b0;
        if (l_q.next_v && !ack) begin
          l_d.dmarq  = 1'b1;
          l_d.mode   = (l_q.mode_m2 > `UDB_MODE_TOP) ? `UDB_MODE_TOP : l_q.mode_m2;
          l_d.t_last = `UDB_CNT_MAX;
          l_d.t_prev = `UDB_CNT_MAX;
          l_d.st     = S_REQ;
        end
      end
      S_REQ: begin
        if (ack) begin
          l_d.tmr = '0;
          l_d.st  = S_ZIO;
        end
      end
      S_ZIO: begin
        if (elapsed(l_q.tmr, cyc_up(`UDB_T_ZIORDY))) begin
          l_d.strb_oe = 1'b1;
          l_d.strb    = 1'b1;
          l_d.st      = S_RDY;
        end
      end
      S_RDY: begin
        if (!stop && rdy) begin
          l_d.tmr = '0;
          l_d.st  = S_ZAD;
        end
      end
      S_ZAD: begin
        if (elapsed(l_q.tmr, cyc_up(`UDB_T_ZAD))) begin
          l_d.dd     = l_q.next_q;
          l_d.dd_oe  = 1'b1;
          l_d.next_v = 1'b0;
          l_d.tmr    = '0;
          l_d.st     = S_SETUP;
        end
      end
      S_SETUP: begin
        if (stop && !rdy) begin
          l_d.dmarq = 1'b0;
          l_d.dd_oe = 1'b0;
          l_d.strb  = 1'b1;
          l_d.st    = S_END;
        end else if (rdy && edge_ok && elapsed(l_q.tmr, cyc_up(t_dvs(l_q.mode)))) begin
          l_d.strb   = !l_q.strb;
          l_d.t_prev = l_q.t_last;
          l_d.t_last = '0;
          l_d.tmr    = '0;
          l_d.st     = S_HOLD;
        end
      end
      S_HOLD: begin
        if (elapsed(l_q.tmr, cyc_up(`UDB_T_DVH))) begin
          l_d.st = S_WAIT;
        end
      end
      S_WAIT: begin
        if (stop && !rdy) begin
          // Host ends the burst: drop request, park strobe high, free bus
          l_d.dmarq = 1'b0;
          l_d.dd_oe = 1'b0;
          l_d.strb  = 1'b1;
          l_d.st    = S_END;
        end else if (l_q.next_v && rdy) begin
          l_d.dd     = l_q.next_q;
          l_d.next_v = 1'b0;
          l_d.tmr    = '0;
          l_d.st     = S_SETUP;
        end
      end
      S_END: begin
        l_d.dmarq = 1'b0;
        l_d.dd_oe = 1'b0;
      end
      default: begin
        l_d.st = S_IDLE;
      end
    endcase

    // release strobe only after acknowledge drops
    if ((l_q.st != S_IDLE) && (l_q.st != S_REQ) && !ack) begin
      l_d.dmarq   = 1'b0;
      l_d.strb_oe = 1'b0;
      l_d.dd_oe   = 1'b0;
      l_d.st      = S_IDLE;
    end
  end

  // Link state register
  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_q <= UDB_LINK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // Core side word slot with toggle handshake to the link
  always_comb begin
    c_d        = c_q;
    c_d.ack_m1 = l_q.ack_t;
    c_d.ack_m2 = c_q.ack_m1;
    c_d.act_m1 = l_q.dmarq;
    c_d.act_m2 = c_q.act_m1;
    if (!c_q.ready && (c_q.ack_m2 == c_q.req_t)) begin
      c_d.ready = 1'b1;
    end
    if (c_q.ready && word_valid_in) begin
      c_d.word  = word_data_in;
      c_d.req_t = !c_q.req_t;
      c_d.ready = 1'b0;
    end
  end

  // Core state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      c_q <= UDB_CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // Outputs straight from flops
  assign word_ready_out   = c_q.ready;
  assign burst_active_out = c_q.act_m2;
  assign dmarq_out        = l_q.dmarq;
  assign dstrobe_out      = l_q.strb;
  assign dstrobe_oe_out   = l_q.strb_oe;
  assign dd_out           = l_q.dd;
  assign dd_oe_out        = l_q.dd_oe;

endmodule : udb_data_in

// ### udb_data_in_chk.sv
// Pin timing checker for the data-in burst engine
`timescale 1ns/100ps
module udb_data_in_chk
  import udb_pkg::*;
(
  input wire logic      clk_in,           // Core clock
  input wire logic      nrst_in,          // Reset
  input wire logic      link_clk_in,      // Link clock
  input wire udb_mode_t mode_in,          // Mode
  input wire logic      word_valid_in,    // Word valid
  input wire udb_word_t word_data_in,     // Word
  input wire logic      word_ready_out,   // Slot free
  input wire logic      burst_active_out, // Burst on
  input wire logic      dmarq_out,        // Request
  input wire logic      dmack_n_in,       // Acknowledge
  input wire logic      stop_in,          // Stop
  input wire logic      hdmardy_n_in,     // Host ready
  input wire logic      dstrobe_in,       // Strobe level
  input wire logic      dstrobe_out,      // Strobe value
  input wire logic      dstrobe_oe_out,   // Strobe enable
  input wire udb_word_t dd_in,            // Bus level
  input wire udb_word_t dd_out,           // Bus value
  input wire logic      dd_oe_out         // Bus enable
);
  logic [3:0] off_q; // Cycles with host ready negated

  default clocking @(posedge link_clk_in); endclocking
  default disable iff (!nrst_in);

  // Count how long the host has held off
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      off_q <= 4'h0;
    else if (!hdmardy_n_in)
      off_q <= 4'h0;
    else if (off_q != 4'hf)
      off_q <= off_q + 4'h1;
  end

  a_req_kept: assert property ($fell(dmarq_out) |-> $past(stop_in) || $past(dmack_n_in))
    else $error("request dropped early");
  a_strb_late: assert property ($rose(dstrobe_oe_out) |-> $past(!dmack_n_in, 3))
    else $error("strobe driven too soon");
  a_strb_kept: assert property (dstrobe_oe_out && !dmack_n_in |=> dstrobe_oe_out)
    else $error("strobe released early");
  a_data_late: assert property ($rose(dd_oe_out) |-> $past(!stop_in && !hdmardy_n_in, 2))
    else $error("data driven too soon");
  a_first_high: assert property ($rose(dd_oe_out) |-> dstrobe_out && dmarq_out)
    else $error("first edge not a fall");
  a_data_setup: assert property ($changed(dstrobe_out) && dd_oe_out |-> dd_out == $past(dd_out, 2))
    else $error("data setup short");
  a_data_hold: assert property ($changed(dstrobe_out) && dd_oe_out |=> ($stable(dd_out) || !dd_oe_out) [*2])
    else $error("data hold short");
  a_edge_gap: assert property ($changed(dstrobe_out) && dd_oe_out |=> ($stable(dstrobe_out) || !dd_oe_out) [*4])
    else $error("strobe edges too close");
  a_pause_quiet: assert property (off_q >= 4'h8 && dd_oe_out |-> $stable(dstrobe_out))
    else $error("strobe edge during pause");

  c_first: cover property ($rose(dd_oe_out));
  c_pause: cover property (off_q == 4'h8 && dd_oe_out);
  c_end: cover property ($fell(dmarq_out));
endmodule : udb_data_in_chk

bind udb_data_in udb_data_in_chk u_chk (.*);

// ### udb_data_in_test.sv
// Testbench for the data-in burst engine
`timescale 1ns/100ps
`include "udb_params.svh"
module udb_data_in_test
  import udb_pkg::*;
;
  logic      clk_in, nrst_in, link_clk, valid, pause, end_b, ready, active;
  logic      dmarq, dmack_n, stop, rdy_n, strb, strb_oe, dd_oe, strb_bus;
  udb_mode_t mode;
  udb_word_t wdata, dd, dd_last, dd_bus;
  udb_word_t exp_q[$];
  int        n_fail, cmp_count;
  real       cyc_ns[5] = '{`UDB_T_CYC_M0 / 10.0, `UDB_T_CYC_M1 / 10.0, `UDB_T_CYC_M2 / 10.0,
                           `UDB_T_CYC_M3 / 10.0, `UDB_T_CYC_M4 / 10.0};

  // Pulled-up strobe line, released bus shows inverted last value
  assign strb_bus = strb_oe ? strb : 1'b1;
  assign dd_bus = dd_oe ? dd : ~dd_last;
  always @(posedge link_clk) if (dd_oe) dd_last <= dd;

  udb_data_in u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .link_clk_in(link_clk),
    .mode_in(mode), .word_valid_in(valid), .word_data_in(wdata), .word_ready_out(ready),
    .burst_active_out(active), .dmarq_out(dmarq), .dmack_n_in(dmack_n), .stop_in(stop),
    .hdmardy_n_in(rdy_n), .dstrobe_in(strb_bus), .dstrobe_out(strb), .dstrobe_oe_out(strb_oe),
    .dd_in(dd_bus), .dd_out(dd), .dd_oe_out(dd_oe));

  udb_host_model u_host (.dmarq_in(dmarq), .strb_in(strb_bus), .dd_in(dd_bus),
    .pause_in(pause), .end_in(end_b), .dmack_n_out(dmack_n), .stop_out(stop),
    .hdmardy_n_out(rdy_n));

  // Core clock and phase-shifted link clock
  always #5 clk_in = ~clk_in;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic send(input udb_word_t w);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 500) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 500) n_fail++; // Stalled slot counts as a mismatch
    valid = 1'b1;
    wdata = w;
    exp_q.push_back(w);
    @(negedge clk_in);
    valid = 1'b0;
  endtask : send

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (u_host.rx_q.size() < n && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 3000) n_fail++; // Missing words count as a mismatch
  endtask : wait_rx

  task automatic cmp_words;
    chk("count", 16'(u_host.rx_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) chk("word", u_host.rx_q[i], exp_q[i]);
    exp_q.delete();
    u_host.rx_q.delete();
  endtask : cmp_words

  task automatic end_burst;
    int k;
    k = 0;
    end_b = 1'b1;
    while (dmack_n !== 1'b1 && k < 100) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 100) n_fail++; // Hung acknowledge counts as a mismatch
    repeat (10) @(negedge clk_in);
    chk("release", {active, dmarq, strb_oe, dd_oe}, 16'h0000);
    end_b = 1'b0;
  endtask : end_burst

  task automatic t_idle;
    repeat (3) @(negedge clk_in);
    chk("idle", {ready, active, dmarq, strb_oe, dd_oe}, 16'h0010);
  endtask : t_idle

  task automatic t_modes;
    for (int m = 0; m < 5; m++) begin
      mode = udb_mode_t'(m);
      repeat (5) @(negedge clk_in);
      u_host.gap_min = 1.0e6;
      for (int i = 0; i < 3; i++) send(16'ha500 + 16'(m * 16 + i));
      wait_rx(3);
      chk("active", 16'(active), 16'h0001);
      cmp_words();
      chk("gap", u_host.gap_min + 0.05 >= cyc_ns[m], 16'h0001);
      end_burst();
    end
  endtask : t_modes

  task automatic t_pause;
    int got;
    send(16'hc000);
    wait_rx(1);
    pause = 1'b1;
    send(16'hc001);
    send(16'hc002);
    repeat (30) @(negedge clk_in);
    got = u_host.rx_q.size();
    // Nothing was queued when the pause began, so only the first word is in
    chk("paused", 16'(got), 16'h0001);
    repeat (30) @(negedge clk_in);
    chk("quiet", 16'(u_host.rx_q.size()), 16'(got));
    pause = 1'b0;
    send(16'hc003);
    wait_rx(4);
    cmp_words();
    end_burst();
  endtask : t_pause

  initial begin
    clk_in = 1'b0;
    link_clk = 1'b0;
    nrst_in = 1'b0;
    valid = 1'b0;
    pause = 1'b0;
    end_b = 1'b0;
    mode = 3'h0;
    wdata = '0;
    dd_last = '0;
    n_fail = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'b1;
    t_idle();
    t_modes();
    t_pause();
    print_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end
endmodule : udb_data_in_test

// ### udb_host_model.sv
// Host end of a data-in burst with pause and termination on command
`timescale 1ns/100ps
module udb_host_model
  import udb_pkg::*;
(
  input  wire logic      dmarq_in,     // Device request
  input  wire logic      strb_in,      // Strobe line
  input  wire udb_word_t dd_in,        // Data bus
  input  wire logic      pause_in,     // Pause command
  input  wire logic      end_in,       // End command
  output logic           dmack_n_out,  // Acknowledge
  output logic           stop_out,     // Stop
  output logic           hdmardy_n_out // Ready, low active
);
  logic      rdy_n;
  udb_word_t rx_q[$];
  realtime   t_last;
  realtime   gap_min;

  assign hdmardy_n_out = rdy_n | pause_in;

  initial begin
    dmack_n_out = 1'b1;
    stop_out = 1'b1;
    rdy_n = 1'b1;
    forever begin
      wait (dmarq_in === 1'b1);
      // Delays keep pin changes off the link clock edges
      #31 dmack_n_out = 1'b0;
      t_last = 0;
      #25 stop_out = 1'b0;
      rdy_n = 1'b0;
      wait (end_in === 1'b1);
      rdy_n = 1'b1;
      #60 stop_out = 1'b1;
      #60 dmack_n_out = 1'b1;
      wait (end_in === 1'b0);
    end
  end

  // never drives data, takes every edge of the burst before STOP
  always @(strb_in) begin
    // Strobe rise after STOP carries no data and is ignored
    if (dmarq_in === 1'b1 && dmack_n_out === 1'b0 && stop_out === 1'b0) begin
      rx_q.push_back(dd_in);
      if (t_last > 0 && $realtime - t_last < gap_min)
        gap_min = $realtime - t_last;
      t_last = $realtime;
    end
  end
endmodule : udb_host_model

// ### udb_params.svh
// Timing and width constants for the data-in burst engine
`ifndef UDB_PARAMS_SVH
`define UDB_PARAMS_SVH

// Data bus width and timer width
`define UDB_DW          16
`define UDB_CNT_W       8
`define UDB_CNT_MAX     8'hff
`define UDB_MODE_W      3
`define UDB_MODE_TOP    3'h4

// Link clock period in tenths of a ns (6.0 ns)
`define UDB_LINK_PER_X10 16'h003c

// Data valid setup at sender per mode, tenths of ns (72.9 50.9 33.9 22.6 9.5)
`define UDB_T_DVS_M0    16'h02d9
`define UDB_T_DVS_M1    16'h01fd
`define UDB_T_DVS_M2    16'h0153
`define UDB_T_DVS_M3    16'h00e2
`define UDB_T_DVS_M4    16'h005f

// Data valid hold at sender, tenths of ns (9.0)
`define UDB_T_DVH       16'h005a

// Strobe edge spacing per mode, tenths of ns (100 80 60 40 30, plain defaults)
`define UDB_T_CYC_M0    16'h03e8
`define UDB_T_CYC_M1    16'h0320
`define UDB_T_CYC_M2    16'h0258
`define UDB_T_CYC_M3    16'h0190
`define UDB_T_CYC_M4    16'h012c

// Strobe drive delay and data drive delay, tenths of ns (plain defaults)
`define UDB_T_ZIORDY    16'h0000
`define UDB_T_ZAD       16'h0000

`endif

// ### udb_pkg.sv
// Types shared by the data-in burst engine
package udb_pkg;
`include "udb_params.svh"

  // Link side sequencer states
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_REQ   = 9'h002,
    S_ZIO   = 9'h004,
    S_RDY   = 9'h008,
    S_ZAD   = 9'h010,
    S_SETUP = 9'h020,
    S_HOLD  = 9'h040,
    S_WAIT  = 9'h080,
    S_END   = 9'h100
  } udb_state_e;

  typedef logic [`UDB_CNT_W-1:0]  udb_cnt_t;
  typedef logic [`UDB_DW-1:0]     udb_word_t;
  typedef logic [`UDB_MODE_W-1:0] udb_mode_t;

  // All state on the link clock
  typedef struct packed {
    udb_state_e st;
    udb_mode_t  mode_m1;
    udb_mode_t  mode_m2;
    udb_mode_t  mode;
    logic       ack_n_m1;
    logic       ack_n_m2;
    logic       stop_m1;
    logic       stop_m2;
    logic       rdy_n_m1;
    logic       rdy_n_m2;
    logic       req_m1;
    logic       req_m2;
    logic       ack_t;
    logic       next_v;
    udb_word_t  next_q;
    logic       dmarq;
    logic       strb;
    logic       strb_oe;
    logic       dd_oe;
    udb_word_t  dd;
    udb_cnt_t   tmr;
    udb_cnt_t   t_last;
    udb_cnt_t   t_prev;
  } udb_link_s;

  // All state on the core clock
  typedef struct packed {
    udb_word_t word;
    logic      req_t;
    logic      ack_m1;
    logic      ack_m2;
    logic      ready;
    logic      act_m1;
    logic      act_m2;
  } udb_core_s;

  localparam udb_link_s UDB_LINK_RST = '{st: S_IDLE, ack_n_m1: 1'b1, ack_n_m2: 1'b1,
                                         rdy_n_m1: 1'b1, rdy_n_m2: 1'b1, default: '0};
  localparam udb_core_s UDB_CORE_RST = '{ready: 1'b1, default: '0};

endpackage : udb_pkg
